// ---- reader_timer_block.sv ----
// second and third down timers with their register file on avalon-mm
// Function
// [RULE1] stop-on-receive set: halt count once first 4 received bits arrive
// [RULE2] stop-on-receive has no effect while slow-oscillator trimming
// [RULE3] start mode 00 never auto starts; 01 starts after transmission
// [RULE4] modes 10/11 trim, without/with underflow, start/stop on rising edge
// [RULE5] auto-restart reloads at zero and continues; otherwise stops
// [RULE6] every underflow sets the second timer interrupt flag
// [RULE7] clock select: carrier, 212 kHz, timer0 or timer1 underflow
// [RULE8] each start loads the 16-bit reload value from both bytes
// [RULE9] reload writes leave a running count alone until next start
// [RULE10] live count readable as high/low bytes; avoid during reception
// [RULE11] first timer count low byte readable live
// [RULE12] third timer has the same start, stop and restart behaviour
// [RULE13] one decrement per tick; underflow is a one-cycle pulse
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

module reader_timer_block (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm slave, byte address
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // count clock pulses and neighbouring timers
   input wire logic carrier_tick,
   input wire logic div212_tick,
   input wire logic timer0_underflow,
   input wire logic timer1_underflow,
   input wire logic [15:0] first_count,
   // frame events and trimmed oscillator level
   input wire logic tx_done,
   input wire logic rx_nibble,
   input wire logic slow_oscillator,
   // timer state
   output logic second_timer_irq_flag,
   output logic third_timer_irq_flag,
   output logic second_underflow,
   output logic third_underflow,
   output logic second_running,
   output logic third_running
);

   timer_pkg::control_type t2_ctrl_reg;
   timer_pkg::control_type t3_ctrl_reg;
   timer_pkg::events_type events;
   logic [7:0] t2_reload_high_reg;
   logic [7:0] t2_reload_low_reg;
   logic [7:0] t3_reload_high_reg;
   logic [7:0] t3_reload_low_reg;
   logic [15:0] t2_count;
   logic [15:0] t3_count;
   logic [3:0] tick_sources;
   logic osc_rise;
   logic ack_reg;
   logic [31:0] readdata_reg;
   logic [31:0] rdata_next;
   logic wr_take;
   logic [1:0] irq_set;
   logic [1:0] irq_clear;
   logic [1:0] irq_reg;

   function automatic logic [7:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction

   function automatic logic [7:0] masked_ctrl(input logic [7:0] data);
      masked_ctrl = data & `CONTROL_WRITE_MASK;
   endfunction

   rise_detect osc_edge (
      .clk(clk),
      .rst_n(rst_n),
      .level(slow_oscillator),
      .rise(osc_rise)
   );

   // clock-select index order is the field encoding
   assign tick_sources = {timer1_underflow, timer0_underflow,
      div212_tick, carrier_tick}; // [RULE7]
   assign events = '{tx_done: tx_done, rx_nibble: rx_nibble,
      osc_rise: osc_rise};

   count_timer second_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ctrl(t2_ctrl_reg),
      .reload({t2_reload_high_reg, t2_reload_low_reg}), // [RULE8]
      .tick_sources(tick_sources),
      .events(events),
      .count_reg(t2_count),
      .underflow_reg(second_underflow),
      .running(second_running)
   );

   count_timer third_timer (
      .clk(clk),
      .rst_n(rst_n),
      .ctrl(t3_ctrl_reg),
      .reload({t3_reload_high_reg, t3_reload_low_reg}),
      .tick_sources(tick_sources),
      .events(events),
      .count_reg(t3_count),
      .underflow_reg(third_underflow),
      .running(third_running)
   ); // [RULE12]

   // one wait state: data is captured on the first edge and shown next
   assign waitrequest = (read || write) && !ack_reg;
   assign readdata = readdata_reg;
   assign wr_take = write && ack_reg && byteenable[0];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ack_reg <= 1'b0;
      else
         ack_reg <= (read || write) && !ack_reg;
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      unique case (address)
         byte_addr(`IDX_T1_COUNT_LOW):
            rdata_next[7:0] = first_count[7:0]; // [RULE11]
         byte_addr(`IDX_T2_CONTROL):
            rdata_next[7:0] = t2_ctrl_reg;
         byte_addr(`IDX_T2_RELOAD_HIGH):
            rdata_next[7:0] = t2_reload_high_reg;
         byte_addr(`IDX_T2_RELOAD_LOW):
            rdata_next[7:0] = t2_reload_low_reg;
         byte_addr(`IDX_T2_COUNT_HIGH):
            rdata_next[7:0] = t2_count[15:8]; // [RULE10]
         byte_addr(`IDX_T2_COUNT_LOW):
            rdata_next[7:0] = t2_count[7:0]; // [RULE10]
         byte_addr(`IDX_T3_CONTROL):
            rdata_next[7:0] = t3_ctrl_reg;
         byte_addr(`IDX_T3_RELOAD_HIGH):
            rdata_next[7:0] = t3_reload_high_reg;
         byte_addr(`IDX_T3_RELOAD_LOW):
            rdata_next[7:0] = t3_reload_low_reg;
         byte_addr(`IDX_IRQ_STATUS):
            rdata_next[1:0] = irq_reg;
         default:
            rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         readdata_reg <= 32'h0000_0000;
      else if (read && !ack_reg)
         readdata_reg <= rdata_next;
   end

   // control bytes; reserved bits are never stored
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         t2_ctrl_reg <= `CONTROL_RESET;
         t3_ctrl_reg <= `CONTROL_RESET;
      end
      else if (wr_take)
      begin
         if (address == byte_addr(`IDX_T2_CONTROL))
            t2_ctrl_reg <= masked_ctrl(writedata[7:0]);
         if (address == byte_addr(`IDX_T3_CONTROL))
            t3_ctrl_reg <= masked_ctrl(writedata[7:0]);
      end
   end

   // reload bytes feed the counter at a start event and at an auto-restart reload
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         t2_reload_high_reg <= `RELOAD_RESET;
         t2_reload_low_reg <= `RELOAD_RESET;
         t3_reload_high_reg <= `RELOAD_RESET;
         t3_reload_low_reg <= `RELOAD_RESET;
      end
      else if (wr_take)
      begin
         if (address == byte_addr(`IDX_T2_RELOAD_HIGH))
            t2_reload_high_reg <= writedata[7:0]; // [RULE9]
         if (address == byte_addr(`IDX_T2_RELOAD_LOW))
            t2_reload_low_reg <= writedata[7:0]; // [RULE9]
         if (address == byte_addr(`IDX_T3_RELOAD_HIGH))
            t3_reload_high_reg <= writedata[7:0];
         if (address == byte_addr(`IDX_T3_RELOAD_LOW))
            t3_reload_low_reg <= writedata[7:0];
      end
   end

   // write one to clear; a same-cycle underflow keeps the flag set
   assign irq_set = {third_underflow, second_underflow};
   assign irq_clear = (wr_take && address == byte_addr(`IDX_IRQ_STATUS)) ?
      writedata[1:0] : 2'b00;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         irq_reg <= 2'b00;
      else
         irq_reg <= irq_set | (irq_reg & ~irq_clear); // [RULE6]
   end

   assign second_timer_irq_flag = irq_reg[`IRQ_BIT_SECOND];
   assign third_timer_irq_flag = irq_reg[`IRQ_BIT_THIRD];

   property p_irq_second;
      @(posedge clk) disable iff (!rst_n)
      second_underflow |=> second_timer_irq_flag;
   endproperty
   a_irq_second: assert property (p_irq_second) // [RULE6]
      else $error("second timer underflow did not set its flag");

   property p_irq_third;
      @(posedge clk) disable iff (!rst_n)
      third_underflow |=> third_timer_irq_flag;
   endproperty
   a_irq_third: assert property (p_irq_third) // [RULE12]
      else $error("third timer underflow did not set its flag");

   property p_irq_sticky;
      @(posedge clk) disable iff (!rst_n)
      second_timer_irq_flag && !(wr_take &&
         address == byte_addr(`IDX_IRQ_STATUS) && writedata[0])
      |=> second_timer_irq_flag;
   endproperty
   a_irq_sticky: assert property (p_irq_sticky) // [RULE6]
      else $error("interrupt flag dropped without a clear");

   sequence s_read_req(logic [7:0] idx);
      read && !ack_reg && address == byte_addr(idx);
   endsequence

   property p_count_high_read;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(`IDX_T2_COUNT_HIGH)
      |=> !waitrequest && readdata[7:0] == $past(t2_count[15:8]);
   endproperty
   a_count_high_read: assert property (p_count_high_read) // [RULE10]
      else $error("count high byte read wrong");

   property p_count_low_read;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(`IDX_T2_COUNT_LOW)
      |=> readdata == {24'h000000, $past(t2_count[7:0])};
   endproperty
   a_count_low_read: assert property (p_count_low_read) // [RULE10]
      else $error("count low byte read wrong");

   property p_first_low_read;
      @(posedge clk) disable iff (!rst_n)
      s_read_req(`IDX_T1_COUNT_LOW)
      |=> readdata[7:0] == $past(first_count[7:0]);
   endproperty
   a_first_low_read: assert property (p_first_low_read) // [RULE11]
      else $error("first timer count byte read wrong");

   property p_clock_select;
      @(posedge clk) disable iff (!rst_n)
      second_running && t2_ctrl_reg.clock_select == `CLK_DIV212 &&
         !div212_tick && !events.osc_rise && !rx_nibble
      |=> $stable(t2_count);
   endproperty
   a_clock_select: assert property (p_clock_select) // [RULE7]
      else $error("count moved without the selected tick");

   property p_one_wait;
      @(posedge clk) disable iff (!rst_n)
      (read || write) && !ack_reg |=> !waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus answer not given after one wait state");

endmodule

`default_nettype wire

// ---- timer_params.svh ----
// register map, field positions and reset values of the timer block
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_T1_COUNT_LOW 8'h18
`define IDX_T2_CONTROL 8'h19
`define IDX_T2_RELOAD_HIGH 8'h1a
`define IDX_T2_RELOAD_LOW 8'h1b
`define IDX_T2_COUNT_HIGH 8'h1c
`define IDX_T2_COUNT_LOW 8'h1d
`define IDX_T3_CONTROL 8'h1e
`define IDX_T3_RELOAD_HIGH 8'h1f
`define IDX_T3_RELOAD_LOW 8'h20
`define IDX_IRQ_STATUS 8'h30

// control byte: bits 6 and 2 are reserved and read zero
`define CONTROL_WRITE_MASK 8'hbb
`define CONTROL_RESET 8'h00
`define RELOAD_RESET 8'h00
`define IRQ_BIT_SECOND 0
`define IRQ_BIT_THIRD 1

// start-mode encodings
`define START_NONE 2'h0
`define START_AFTER_TX 2'h1
`define START_TRIM_NO_UFLOW 2'h2
`define START_TRIM_UFLOW 2'h3

// clock-select encodings
`define CLK_CARRIER 2'h0
`define CLK_DIV212 2'h1
`define CLK_TIMER0_UFLOW 2'h2
`define CLK_TIMER1_UFLOW 2'h3

`endif

// ---- timer_pkg.sv ----
// types shared by the timer block
package timer_pkg;

   typedef struct packed {
      logic stop_on_receive;
      logic reserved_6;
      logic [1:0] start_mode;
      logic auto_restart;
      logic reserved_2;
      logic [1:0] clock_select;
   } control_type;

   typedef struct packed {
      logic tx_done;
      logic rx_nibble;
      logic osc_rise;
   } events_type;

   typedef enum logic {
      IDLE = 1'b0,
      RUN = 1'b1
   } state_type;

endpackage

// ---- rise_detect.sv ----
// rising-edge detector for a synchronous level
`timescale 1ns/100ps
`default_nettype none

module rise_detect (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in, edge out
   input wire logic level,
   output logic rise
);

   logic prev_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_reg <= 1'b0;
      else
         prev_reg <= level;
   end

   assign rise = level & ~prev_reg;

endmodule

`default_nettype wire

// ---- count_timer.sv ----
// one 16-bit down-counting timer with auto start, stop and reload
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

module count_timer (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration
   input wire timer_pkg::control_type ctrl,
   input wire logic [15:0] reload,
   // count clock candidates, indexed by clock_select
   input wire logic [3:0] tick_sources,
   input wire timer_pkg::events_type events,
   // state
   output logic [15:0] count_reg,
   output logic underflow_reg,
   output logic running
);

   timer_pkg::state_type state_reg;
   logic trim;
   logic tick;
   logic start_ev;
   logic trim_stop;
   logic rx_stop;
   logic zero_hit;
   logic uflow;
   logic hold_zero;

   assign running = (state_reg == timer_pkg::RUN);
   assign trim = ctrl.start_mode[1];
   assign tick = tick_sources[ctrl.clock_select];
   assign start_ev = !running &&
      ((ctrl.start_mode == `START_AFTER_TX && events.tx_done) ||
       (trim && events.osc_rise)); // [RULE3] [RULE4]
   assign trim_stop = running && trim && events.osc_rise; // [RULE4]
   // receive stop is masked while trimming
   assign rx_stop = running && ctrl.stop_on_receive && !trim &&
      events.rx_nibble; // [RULE1] [RULE2]
   assign zero_hit = running && tick && count_reg == 16'h0000;
   // trimming without underflow parks at zero until the closing edge
   assign hold_zero = ctrl.start_mode == `START_TRIM_NO_UFLOW;
   assign uflow = zero_hit && !hold_zero;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_reg <= timer_pkg::IDLE;
      else if (start_ev)
         state_reg <= timer_pkg::RUN;
      else if (trim_stop || rx_stop)
         state_reg <= timer_pkg::IDLE; // [RULE1]
      else if (uflow && !ctrl.auto_restart)
         state_reg <= timer_pkg::IDLE; // [RULE5]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count_reg <= 16'h0000;
      else if (start_ev)
         count_reg <= reload; // [RULE8] [RULE9]
      else if (uflow && ctrl.auto_restart)
         count_reg <= reload; // [RULE5]
      else if (running && tick && !rx_stop && !trim_stop && !zero_hit)
         count_reg <= count_reg - 16'h0001; // [RULE13]
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         underflow_reg <= 1'b0;
      else
         underflow_reg <= uflow; // [RULE13]
   end

   property p_rx_stop;
      @(posedge clk) disable iff (!rst_n)
      rx_stop |=> !running;
   endproperty
   a_rx_stop: assert property (p_rx_stop) // [RULE1]
      else $error("timer kept running after receive stop");

   property p_trim_ignores_rx;
      @(posedge clk) disable iff (!rst_n)
      running && trim && events.rx_nibble && !events.osc_rise && !uflow
      |=> running;
   endproperty
   a_trim_ignores_rx: assert property (p_trim_ignores_rx) // [RULE2]
      else $error("receive stop acted during trimming");

   property p_no_auto_start;
      @(posedge clk) disable iff (!rst_n)
      !running && ctrl.start_mode == `START_NONE |=> !running;
   endproperty
   a_no_auto_start: assert property (p_no_auto_start) // [RULE3]
      else $error("timer started with start mode none");

   property p_start_load;
      @(posedge clk) disable iff (!rst_n)
      start_ev |=> running && count_reg == $past(reload);
   endproperty
   a_start_load: assert property (p_start_load) // [RULE8]
      else $error("start did not load reload value");

   property p_count_stable;
      @(posedge clk) disable iff (!rst_n)
      !start_ev && !tick |=> $stable(count_reg);
   endproperty
   a_count_stable: assert property (p_count_stable) // [RULE9]
      else $error("count moved without tick or start");

   sequence s_wrap;
      // a stop in the same cycle ends the run, though the count still reloads
      uflow && ctrl.auto_restart && !rx_stop && !trim_stop;
   endsequence

   property p_restart;
      @(posedge clk) disable iff (!rst_n)
      s_wrap |=> running && underflow_reg && count_reg == $past(reload);
   endproperty
   a_restart: assert property (p_restart) // [RULE5]
      else $error("auto restart failed to reload");

   property p_stop_at_zero;
      @(posedge clk) disable iff (!rst_n)
      uflow && !ctrl.auto_restart |=> !running && count_reg == 16'h0000;
   endproperty
   a_stop_at_zero: assert property (p_stop_at_zero) // [RULE5]
      else $error("timer did not stop at zero");

   property p_decrement;
      @(posedge clk) disable iff (!rst_n)
      running && tick && count_reg != 16'h0000 && !rx_stop && !trim_stop
      |=> count_reg == $past(count_reg) - 16'h0001;
   endproperty
   a_decrement: assert property (p_decrement) // [RULE13]
      else $error("count did not decrement by one");

endmodule

`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench of the reader timer block
`timescale 1ns/100ps
`default_nettype none
`include "timer_params.svh"

module testbench;
   logic clk, rst_n, read, write;
   logic [7:0] address;
   logic [31:0] writedata, readdata, rv;
   logic [3:0] byteenable, tk;
   logic waitrequest, tx_done, rx_nibble, slow_oscillator;
   logic [15:0] first_count;
   logic second_timer_irq_flag, third_timer_irq_flag;
   logic second_underflow, third_underflow, second_running, third_running;
   int error_cnt, n_checks;

   reader_timer_block DUT (
      .clk(clk),
      .rst_n(rst_n),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .carrier_tick(tk[0]),
      .div212_tick(tk[1]),
      .timer0_underflow(tk[2]),
      .timer1_underflow(tk[3]),
      .first_count(first_count),
      .tx_done(tx_done),
      .rx_nibble(rx_nibble),
      .slow_oscillator(slow_oscillator),
      .second_timer_irq_flag(second_timer_irq_flag),
      .third_timer_irq_flag(third_timer_irq_flag),
      .second_underflow(second_underflow),
      .third_underflow(third_underflow),
      .second_running(second_running),
      .third_running(third_running)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   function automatic logic [7:0] ad(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction

   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: value %h, expected %h", $time, seen, exp);
      end
   endtask

   // request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic [7:0] a, input logic [31:0] d,
                      input logic we, input logic [3:0] be);
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      write <= we;
      read <= !we;
      // values seen here are those before this edge; watchdog ends a hang
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      rv = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(ad(idx), {24'h0, d}, 1'b1, 4'h1);
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
      bus(ad(idx), 32'h0, 1'b0, 4'h0);
      chk(rv, {24'h0, exp});
   endtask

   task automatic rcount(input logic [15:0] exp);
      rchk(`IDX_T2_COUNT_HIGH, exp[15:8]);
      rchk(`IDX_T2_COUNT_LOW, exp[7:0]);
   endtask

   // count ticks stay high for n back-to-back cycles
   task automatic tick(input int s, input int n);
      @(posedge clk);
      tk <= 4'h1 << s;
      repeat (n - 1) @(posedge clk);
      @(posedge clk);
      tk <= 4'h0;
      @(negedge clk);
   endtask

   // w: 0 end of transmission, 1 first nibble received
   task automatic pulse(input int w);
      @(posedge clk);
      if (w == 0)
         tx_done <= 1'b1;
      else
         rx_nibble <= 1'b1;
      @(posedge clk);
      tx_done <= 1'b0;
      rx_nibble <= 1'b0;
      @(negedge clk);
   endtask

   // edge detector output is not registered; a few cycles are allowed anyway
   task automatic osc_set(input logic v);
      @(posedge clk);
      slow_oscillator <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      rst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'h0;
      tk = 4'h0;
      tx_done = 1'b0;
      rx_nibble = 1'b0;
      slow_oscillator = 1'b0;
      first_count = 16'h5aa5;
      error_cnt = 0;
      n_checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rchk(`IDX_T2_CONTROL, 8'h00);
      rchk(`IDX_T2_RELOAD_HIGH, 8'h00);
      rchk(`IDX_T3_CONTROL, 8'h00);
      rchk(`IDX_T1_COUNT_LOW, 8'ha5);
      wr(`IDX_T1_COUNT_LOW, 8'h3c);
      rchk(`IDX_T1_COUNT_LOW, 8'ha5);
      wr(8'h3f, 8'h77);
      rchk(8'h3f, 8'h00);
      // reserved control bits read back zero
      wr(`IDX_T2_CONTROL, 8'hff);
      rchk(`IDX_T2_CONTROL, 8'hbb);
      bus(ad(`IDX_T2_CONTROL), 32'h0, 1'b1, 4'h0);
      rchk(`IDX_T2_CONTROL, 8'hbb);
      wr(`IDX_T2_CONTROL, 8'h00);
      wr(`IDX_T2_RELOAD_HIGH, 8'h01);
      wr(`IDX_T2_RELOAD_LOW, 8'h02);
      pulse(0);
      chk(second_running, 1'b0);
      wr(`IDX_T2_CONTROL, 8'h10);
      pulse(0);
      chk(second_running, 1'b1);
      rcount(16'h0102);
      // live count must not follow a reload write
      wr(`IDX_T2_RELOAD_HIGH, 8'h00);
      wr(`IDX_T2_RELOAD_LOW, 8'h01);
      rcount(16'h0102);
      tick(0, 3);
      rcount(16'h00ff);
      tick(0, 256);
      chk(second_underflow, 1'b1);
      chk(second_running, 1'b0);
      // the flag follows the underflow pulse by one cycle
      @(negedge clk);
      chk(second_underflow, 1'b0);
      chk(second_timer_irq_flag, 1'b1);
      rchk(`IDX_IRQ_STATUS, 8'h01);
      wr(`IDX_IRQ_STATUS, 8'h01);
      rchk(`IDX_IRQ_STATUS, 8'h00);
      pulse(0);
      rcount(16'h0001);
      wr(`IDX_T2_CONTROL, 8'h18);
      tick(0, 2);
      chk(second_underflow, 1'b1);
      chk(second_running, 1'b1);
      rcount(16'h0001);
      chk(second_timer_irq_flag, 1'b1);
      pulse(1);
      chk(second_running, 1'b1);
      wr(`IDX_T2_CONTROL, 8'h98);
      pulse(1);
      chk(second_running, 1'b0);
      wr(`IDX_T2_RELOAD_LOW, 8'h05);
      for (int s = 0; s < 4; s++)
      begin
         wr(`IDX_T2_CONTROL, 8'h90 | 8'(s));
         pulse(0);
         for (int o = 0; o < 4; o++)
            if (o != s)
               tick(o, 1);
         rcount(16'h0005);
         tick(s, 1);
         rcount(16'h0004);
         pulse(1);
         chk(second_running, 1'b0);
      end
      wr(`IDX_T2_RELOAD_LOW, 8'h02);
      wr(`IDX_T2_CONTROL, 8'ha0);
      osc_set(1'b1);
      chk(second_running, 1'b1);
      rcount(16'h0002);
      pulse(1);
      chk(second_running, 1'b1);
      tick(0, 3);
      chk(second_underflow, 1'b0);
      rcount(16'h0000);
      osc_set(1'b0);
      osc_set(1'b1);
      chk(second_running, 1'b0);
      osc_set(1'b0);
      wr(`IDX_T2_CONTROL, 8'h30);
      osc_set(1'b1);
      chk(second_running, 1'b1);
      tick(0, 3);
      chk(second_underflow, 1'b1);
      chk(second_running, 1'b0);
      // after an underflow stop the next rising edge starts a new run
      osc_set(1'b0);
      osc_set(1'b1);
      chk(second_running, 1'b1);
      rcount(16'h0002);
      osc_set(1'b0);
      osc_set(1'b1);
      chk(second_running, 1'b0);
      wr(`IDX_IRQ_STATUS, 8'h03);
      rchk(`IDX_IRQ_STATUS, 8'h00);
      // third timer repeats the start, restart and stop behaviour
      wr(`IDX_T3_RELOAD_LOW, 8'h01);
      pulse(0);
      chk(third_running, 1'b0);
      wr(`IDX_T3_CONTROL, 8'h18);
      pulse(0);
      chk(third_running, 1'b1);
      tick(0, 2);
      chk(third_underflow, 1'b1);
      chk(third_running, 1'b1);
      @(negedge clk);
      chk(third_timer_irq_flag, 1'b1);
      rchk(`IDX_IRQ_STATUS, 8'h02);
      wr(`IDX_T3_CONTROL, 8'h98);
      pulse(1);
      chk(third_running, 1'b0);
      give_verdict();
   end
endmodule
`default_nettype wire
